// ---- rtl/pmr_regs.sv ----
// Module: result, peak-hold and warning-limit register bank of the power monitor
module pmr_regs #(
	parameter int DATA_W = 16,
	parameter int BUS_W = 13
) (
	input wire logic sys_clk_in,
	input wire logic reset_n_in,
	input wire logic ce_in,
	// Conversion results from the measurement logic
	input wire logic conv_valid_in,
	input wire logic [15:0] shunt_volt_in,
	input wire logic [15:0] calibration_in,
	input wire logic [12:0] bus_volt_count_in,
	input wire logic bus_range_16v_in,
	input wire logic warn_output_enable_in,
	// Register port from the two-wire serial bus engine
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic [15:0] reg_wdata_in,
	output logic [15:0] reg_rdata_out,
	// Status flags and warning pin
	output logic shunt_high_warn_flag_out,
	output logic shunt_low_warn_flag_out,
	output logic power_warn_flag_out,
	output logic bus_overvolt_warn_flag_out,
	output logic warn_level_out,
	output logic warn_oe_out
);
	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	if (DATA_W != 16 || BUS_W != 13) begin : g_bad_width
		$error("pmr_regs supports only 16-bit registers with 13-bit bus field");
	end

	// ----------------------------------------------------------------
	// Reset synchroniser
	// ----------------------------------------------------------------
	logic rst_meta_r;
	logic rst_sync_r;
	// Release reset through two flops
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end
	wire rst_n = rst_sync_r;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [15:0] bus_volt_bits_r;
	logic [15:0] power_bits_r;
	logic [15:0] current_bits_r;
	logic [15:0] shunt_high_peak_bits_r;
	logic [15:0] shunt_low_peak_bits_r;
	logic [15:0] bus_high_peak_bits_r;
	logic [15:0] bus_low_peak_bits_r;
	logic [15:0] power_peak_bits_r;
	logic [15:0] shunt_high_warn_limit_r;
	logic [15:0] shunt_low_warn_limit_r;
	logic [15:0] power_warn_bits_r;
	logic [15:0] bus_overvolt_warn_bits_r;
	logic shunt_high_flag_r;
	logic shunt_low_flag_r;
	logic power_flag_r;
	logic bus_ov_flag_r;
	logic warn_any_r;
	logic warn_latched_r;
	logic [15:0] rdata_r;

	// ----------------------------------------------------------------
	// Write decode
	// ----------------------------------------------------------------
	wire wr_en = ce_in & reg_wr_in;
	wire clr_bit = reg_wdata_in[pmr_pkg::PEAK_CLEAR_POS];
	wire clr_shunt_high = wr_en & clr_bit & (reg_addr_in == pmr_pkg::ADDR_SHUNT_HIGH_PEAK);
	wire clr_shunt_low = wr_en & clr_bit & (reg_addr_in == pmr_pkg::ADDR_SHUNT_LOW_PEAK);
	wire clr_bus_high = wr_en & clr_bit & (reg_addr_in == pmr_pkg::ADDR_BUS_HIGH_PEAK);
	wire clr_bus_low = wr_en & clr_bit & (reg_addr_in == pmr_pkg::ADDR_BUS_LOW_PEAK);
	wire clr_power = wr_en & clr_bit & (reg_addr_in == pmr_pkg::ADDR_POWER_PEAK);
	wire wr_shunt_high_lim = wr_en & (reg_addr_in == pmr_pkg::ADDR_SHUNT_HIGH_LIMIT);
	wire wr_shunt_low_lim = wr_en & (reg_addr_in == pmr_pkg::ADDR_SHUNT_LOW_LIMIT);
	wire wr_power_lim = wr_en & (reg_addr_in == pmr_pkg::ADDR_POWER_LIMIT);
	wire wr_bus_ov_lim = wr_en & (reg_addr_in == pmr_pkg::ADDR_BUS_OV_LIMIT);
	wire conv = ce_in & conv_valid_in;

	// ----------------------------------------------------------------
	// Result arithmetic
	// ----------------------------------------------------------------
	// Bus voltage word: count in 15..3, top bit forced low in 16 V range
	wire bus_top = bus_volt_count_in[12] & ~bus_range_16v_in;
	wire [15:0] bus_word = {bus_top, bus_volt_count_in[11:0], 3'b000};
	wire [12:0] bus_count = bus_word[15:3];
	// Current is shunt times calibration bits 14..0, low 16 bits kept two's complement
	wire signed [31:0] current_full = $signed(shunt_volt_in) * $signed({1'b0, calibration_in[14:0]});
	wire [15:0] current_word = current_full[15:0];
	// Power uses current magnitude times bus count over the divisor
	wire [15:0] current_mag = current_word[15] ? 16'(-current_word) : current_word;
	wire [28:0] power_prod = current_mag * bus_count;
	wire [28:0] power_quot = power_prod / pmr_pkg::POWER_DIVISOR;
	wire [15:0] power_word = (|power_quot[28:16]) ? pmr_pkg::POWER_SAT : power_quot[15:0];

	// ----------------------------------------------------------------
	// Peak tracking bases: a clear restores the reset value first,
	// so a conversion in the same cycle still lands in the peak
	// ----------------------------------------------------------------
	wire [15:0] shunt_high_base = clr_shunt_high ? pmr_pkg::RST_SHUNT_HIGH_PEAK
		: shunt_high_peak_bits_r;
	wire [15:0] shunt_low_base = clr_shunt_low ? pmr_pkg::RST_SHUNT_LOW_PEAK
		: shunt_low_peak_bits_r;
	wire [15:0] bus_high_base = clr_bus_high ? pmr_pkg::RST_ZERO : bus_high_peak_bits_r;
	wire [15:0] bus_low_base = clr_bus_low ? pmr_pkg::RST_BUS_LOW_PEAK : bus_low_peak_bits_r;
	wire [15:0] power_base = clr_power ? pmr_pkg::RST_ZERO : power_peak_bits_r;

	// Peak comparisons, signed for shunt, unsigned for bus and power
	wire shunt_new_high = $signed(shunt_volt_in) > $signed(shunt_high_base);
	wire shunt_new_low = $signed(shunt_volt_in) < $signed(shunt_low_base);
	wire bus_new_high = bus_word[15:3] > bus_high_base[15:3];
	wire bus_new_low = bus_word[15:3] < bus_low_base[15:3];
	wire power_new_high = power_word > power_base;

	// Next peak values
	wire [15:0] shunt_high_nxt = (conv & shunt_new_high) ? shunt_volt_in : shunt_high_base;
	wire [15:0] shunt_low_nxt = (conv & shunt_new_low) ? shunt_volt_in : shunt_low_base;
	wire [15:0] bus_high_nxt = (conv & bus_new_high) ? bus_word : bus_high_base;
	wire [15:0] bus_low_nxt = (conv & bus_new_low) ? bus_word : bus_low_base;
	wire [15:0] power_peak_nxt = (conv & power_new_high) ? power_word : power_base;

	// ----------------------------------------------------------------
	// Warning comparisons against new results
	// ----------------------------------------------------------------
	wire cmp_shunt_high = $signed(shunt_volt_in) > $signed(shunt_high_warn_limit_r);
	wire cmp_shunt_low = $signed(shunt_volt_in) < $signed(shunt_low_warn_limit_r);
	wire cmp_power = power_word > power_warn_bits_r;
	wire cmp_bus_ov = bus_count > bus_overvolt_warn_bits_r[15:3];
	// Any condition, gated by the output enable
	wire warn_any_nxt = warn_output_enable_in
		& (cmp_shunt_high | cmp_shunt_low | cmp_power | cmp_bus_ov);
	wire latch_on = bus_overvolt_warn_bits_r[pmr_pkg::WARN_LATCH_POS];
	wire polarity_high = bus_overvolt_warn_bits_r[pmr_pkg::WARN_POLARITY_POS];

	// ----------------------------------------------------------------
	// Result registers, updated once per conversion
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			bus_volt_bits_r <= pmr_pkg::RST_ZERO;
			power_bits_r <= pmr_pkg::RST_ZERO;
			current_bits_r <= pmr_pkg::RST_ZERO;
		end else if (conv) begin
			bus_volt_bits_r <= bus_word;
			power_bits_r <= power_word;
			current_bits_r <= current_word;
		end
	end

	// Peak-hold registers
	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			shunt_high_peak_bits_r <= pmr_pkg::RST_SHUNT_HIGH_PEAK;
			shunt_low_peak_bits_r <= pmr_pkg::RST_SHUNT_LOW_PEAK;
			bus_high_peak_bits_r <= pmr_pkg::RST_ZERO;
			bus_low_peak_bits_r <= pmr_pkg::RST_BUS_LOW_PEAK;
			power_peak_bits_r <= pmr_pkg::RST_ZERO;
		end else if (ce_in) begin
			shunt_high_peak_bits_r <= shunt_high_nxt;
			shunt_low_peak_bits_r <= shunt_low_nxt;
			bus_high_peak_bits_r <= bus_high_nxt;
			bus_low_peak_bits_r <= bus_low_nxt;
			power_peak_bits_r <= power_peak_nxt;
		end
	end

	// Warning limit registers, written by the host
	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			shunt_high_warn_limit_r <= pmr_pkg::RST_ZERO;
			shunt_low_warn_limit_r <= pmr_pkg::RST_ZERO;
			power_warn_bits_r <= pmr_pkg::RST_ZERO;
			bus_overvolt_warn_bits_r <= pmr_pkg::RST_ZERO;
		end else begin
			if (wr_shunt_high_lim) shunt_high_warn_limit_r <= reg_wdata_in;
			if (wr_shunt_low_lim) shunt_low_warn_limit_r <= reg_wdata_in;
			if (wr_power_lim) power_warn_bits_r <= reg_wdata_in;
			if (wr_bus_ov_lim) bus_overvolt_warn_bits_r <= {reg_wdata_in[15:3], 1'b0,
				reg_wdata_in[1:0]};
		end
	end

	// Status flags and warning condition, once per conversion
	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			shunt_high_flag_r <= 1'b0;
			shunt_low_flag_r <= 1'b0;
			power_flag_r <= 1'b0;
			bus_ov_flag_r <= 1'b0;
			warn_any_r <= 1'b0;
		end else if (conv) begin
			shunt_high_flag_r <= cmp_shunt_high;
			shunt_low_flag_r <= cmp_shunt_low;
			power_flag_r <= cmp_power;
			bus_ov_flag_r <= cmp_bus_ov;
			warn_any_r <= warn_any_nxt;
		end
	end

	// Latched warning: sets on any condition, drops only with latch off
	wire warn_latched_nxt = latch_on & (warn_latched_r | (conv & warn_any_nxt));
	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			warn_latched_r <= 1'b0;
		end else if (ce_in) begin
			warn_latched_r <= warn_latched_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Read mux, registered one cycle after the address
	// ----------------------------------------------------------------
	logic [15:0] rdata_nxt;
	always_comb begin
		unique case (reg_addr_in)
			pmr_pkg::ADDR_BUS_RESULT: rdata_nxt = bus_volt_bits_r;
			pmr_pkg::ADDR_POWER_RESULT: rdata_nxt = power_bits_r;
			pmr_pkg::ADDR_CURRENT_RESULT: rdata_nxt = current_bits_r;
			pmr_pkg::ADDR_SHUNT_HIGH_PEAK: rdata_nxt = shunt_high_peak_bits_r;
			pmr_pkg::ADDR_SHUNT_LOW_PEAK: rdata_nxt = shunt_low_peak_bits_r;
			pmr_pkg::ADDR_BUS_HIGH_PEAK: rdata_nxt = bus_high_peak_bits_r;
			pmr_pkg::ADDR_BUS_LOW_PEAK: rdata_nxt = bus_low_peak_bits_r;
			pmr_pkg::ADDR_POWER_PEAK: rdata_nxt = power_peak_bits_r;
			pmr_pkg::ADDR_SHUNT_HIGH_LIMIT: rdata_nxt = shunt_high_warn_limit_r;
			pmr_pkg::ADDR_SHUNT_LOW_LIMIT: rdata_nxt = shunt_low_warn_limit_r;
			pmr_pkg::ADDR_POWER_LIMIT: rdata_nxt = power_warn_bits_r;
			pmr_pkg::ADDR_BUS_OV_LIMIT: rdata_nxt = bus_overvolt_warn_bits_r;
			default: rdata_nxt = pmr_pkg::RST_ZERO;
		endcase
	end
	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= pmr_pkg::RST_ZERO;
		end else if (ce_in) begin
			rdata_r <= rdata_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Delay of the pin is applied downstream, not in these registers
	wire warn_asserted = latch_on ? warn_latched_r : warn_any_r;
	assign reg_rdata_out = rdata_r;
	assign shunt_high_warn_flag_out = shunt_high_flag_r;
	assign shunt_low_warn_flag_out = shunt_low_flag_r;
	assign power_warn_flag_out = power_flag_r;
	assign bus_overvolt_warn_flag_out = bus_ov_flag_r;
	assign warn_level_out = polarity_high ? warn_asserted : ~warn_asserted;
	// Open-collector: pull low whenever the level is low
	assign warn_oe_out = ~warn_level_out;
endmodule : pmr_regs

// ---- rtl/pmr_pkg.sv ----
// Package: register map, reset values and field positions of the result/peak/warning bank
// Notes on behaviour
// - Bus voltage result is read-only; 13-bit count in bits 15..3, bits 2..0 zero.
// - In the 16 V range bit 15 of the bus voltage result reads zero.
// - Power result equals current magnitude times bus voltage count divided by 5000, read-only.
// - Current result equals shunt voltage times calibration value bits 14..0, read-only.
// - Negative current is two's complement with sign in bit 15.
// - Writing one to bit 0 of a peak register restores its reset value.
// - Shunt high peak keeps the largest signed shunt value; resets to 8000.
// - Shunt low peak keeps the smallest signed shunt value; resets to 7FFF.
// - Bus high peak keeps the largest bus voltage, same layout; resets to zero.
// - Bus low peak keeps the smallest bus voltage; resets to FFF8.
// - Power peak keeps the largest power result; resets to zero.
// - Shunt above high limit sets its flag; warning pin only if enabled.
// - Shunt below low limit sets its flag; warning pin only if enabled.
// - Power above its limit sets its flag; warning pin only if enabled.
// - Shunt limits are signed 16-bit, 10 uV step, full scale +/-32000.
// - Power limit compares directly against the power result, same scaling.
// - Warning delay lives in another register, not in these limit registers.
// - Bus over-voltage limit: bits 15..3 limit, bit 1 polarity, bit 0 latch.
// - Bus voltage above over-voltage limit sets its flag; pin only if enabled.
// - Polarity one makes warning assert high; zero, the default, asserts low.
// - Latch one holds warning once triggered; zero makes it follow comparisons.
package pmr_pkg;
	localparam logic [7:0] ADDR_BUS_RESULT = 8'h04;
	localparam logic [7:0] ADDR_POWER_RESULT = 8'h05;
	localparam logic [7:0] ADDR_CURRENT_RESULT = 8'h06;
	localparam logic [7:0] ADDR_SHUNT_HIGH_PEAK = 8'h07;
	localparam logic [7:0] ADDR_SHUNT_LOW_PEAK = 8'h08;
	localparam logic [7:0] ADDR_BUS_HIGH_PEAK = 8'h09;
	localparam logic [7:0] ADDR_BUS_LOW_PEAK = 8'h0A;
	localparam logic [7:0] ADDR_POWER_PEAK = 8'h0B;
	localparam logic [7:0] ADDR_SHUNT_HIGH_LIMIT = 8'h0C;
	localparam logic [7:0] ADDR_SHUNT_LOW_LIMIT = 8'h0D;
	localparam logic [7:0] ADDR_POWER_LIMIT = 8'h0E;
	localparam logic [7:0] ADDR_BUS_OV_LIMIT = 8'h0F;
	// Reset values
	localparam logic [15:0] RST_ZERO = 16'h0000;
	localparam logic [15:0] RST_SHUNT_HIGH_PEAK = 16'h8000;
	localparam logic [15:0] RST_SHUNT_LOW_PEAK = 16'h7FFF;
	localparam logic [15:0] RST_BUS_LOW_PEAK = 16'hFFF8;
	// Field positions
	localparam int PEAK_CLEAR_POS = 0;
	localparam int WARN_LATCH_POS = 0;
	localparam int WARN_POLARITY_POS = 1;
	localparam int BUS_FIELD_LSB = 3;
	localparam int BUS_TOP_POS = 15;
	// Power divisor and saturation
	localparam logic [28:0] POWER_DIVISOR = 29'd5000;
	localparam logic [15:0] POWER_SAT = 16'hFFFF;
endpackage : pmr_pkg

// ---- test/pmr_regs_sva.sv ----
// Checker: port relations of the result, peak and warning register bank
module pmr_regs_sva (
	input wire logic sys_clk_in,
	input wire logic reset_n_in,
	input wire logic ce_in,
	input wire logic conv_valid_in,
	input wire logic bus_range_16v_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic [15:0] reg_rdata_out,
	input wire logic shunt_high_warn_flag_out,
	input wire logic shunt_low_warn_flag_out,
	input wire logic power_warn_flag_out,
	input wire logic bus_overvolt_warn_flag_out,
	input wire logic warn_level_out,
	input wire logic warn_oe_out
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!reset_n_in);
	wire logic [3:0] flags = {shunt_high_warn_flag_out, shunt_low_warn_flag_out,
		power_warn_flag_out, bus_overvolt_warn_flag_out};
	// Write to a place, then a quiet read of it
	sequence s_clr(logic [7:0] a);
		ce_in && reg_wr_in && !conv_valid_in && reg_addr_in == a && reg_wdata_in[0]
		##1 ce_in && !reg_wr_in && !conv_valid_in && reg_addr_in == a;
	endsequence
	sequence s_lim(logic [7:0] a);
		ce_in && reg_wr_in && reg_addr_in == a ##1 ce_in && !reg_wr_in && reg_addr_in == a;
	endsequence
	sequence s_rng;
		ce_in && conv_valid_in && bus_range_16v_in
		##1 ce_in && !conv_valid_in && reg_addr_in == 8'h04;
	endsequence
	property p_oe; warn_oe_out == !warn_level_out; endproperty
	property p_hold; !(ce_in && conv_valid_in) |=> $stable(flags); endproperty
	property p_low; ce_in && reg_addr_in == 8'h04 |=> reg_rdata_out[2:0] == 3'h0; endproperty
	property p_rng; s_rng |=> !reg_rdata_out[15]; endproperty
	property p_clr_sh; s_clr(8'h07) |=> reg_rdata_out == 16'h8000; endproperty
	property p_clr_bl; s_clr(8'h0A) |=> reg_rdata_out == 16'hFFF8; endproperty
	property p_clr_pp; s_clr(8'h0B) |=> reg_rdata_out == 16'h0000; endproperty
	property p_lim; s_lim(8'h0C) |=> reg_rdata_out == $past(reg_wdata_in, 2); endproperty
	property p_ov; s_lim(8'h0F) |=> reg_rdata_out == ($past(reg_wdata_in, 2) & 16'hFFFB);
	endproperty
	a_oe: assert property (p_oe) else $error("pin enable not inverse of level");
	a_hold: assert property (p_hold) else $error("flags moved without conversion");
	a_low: assert property (p_low) else $error("bus word low bits not zero");
	a_rng: assert property (p_rng) else $error("bus word top bit set in low range");
	a_clr_sh: assert property (p_clr_sh) else $error("shunt high peak not cleared");
	a_clr_bl: assert property (p_clr_bl) else $error("bus low peak not cleared");
	a_clr_pp: assert property (p_clr_pp) else $error("power peak not cleared");
	a_lim: assert property (p_lim) else $error("shunt limit readback wrong");
	a_ov: assert property (p_ov) else $error("bus limit readback wrong");
endmodule : pmr_regs_sva

bind pmr_regs pmr_regs_sva chk_u (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
	.ce_in(ce_in), .conv_valid_in(conv_valid_in), .bus_range_16v_in(bus_range_16v_in),
	.reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in),
	.reg_rdata_out(reg_rdata_out), .shunt_high_warn_flag_out(shunt_high_warn_flag_out),
	.shunt_low_warn_flag_out(shunt_low_warn_flag_out), .power_warn_flag_out(power_warn_flag_out),
	.bus_overvolt_warn_flag_out(bus_overvolt_warn_flag_out), .warn_level_out(warn_level_out),
	.warn_oe_out(warn_oe_out));

// ---- test/pmr_host_model.sv ----
// Partner: host side of the register port, as the serial engine drives it
module pmr_host_model (
	input wire logic sys_clk_in,
	input wire logic [15:0] reg_rdata_in,
	output logic [7:0] reg_addr_out,
	output logic reg_wr_out,
	output logic [15:0] reg_wdata_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle port at time zero
	initial begin
		reg_addr_out = 8'h00;
		reg_wr_out = 1'b0;
		reg_wdata_out = 16'h0000;
	end
	// One-cycle strobe; data inverted once no longer qualified
	task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk_in);
		reg_addr_out <= a;
		reg_wdata_out <= d;
		reg_wr_out <= 1'b1;
		@(posedge sys_clk_in);
		reg_wr_out <= 1'b0;
		reg_wdata_out <= ~d;
	endtask : wr_reg
	// Address one cycle, take registered data in the next
	task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
		@(posedge sys_clk_in);
		reg_addr_out <= a;
		@(posedge sys_clk_in);
		@(negedge sys_clk_in);
		d = reg_rdata_in;
	endtask : rd_reg
	// Restart peak tracking
	task automatic clr_peak(input logic [7:0] a);
		wr_reg(a, 16'h0001);
	endtask : clr_peak
endmodule : pmr_host_model

// ---- test/tb_pmr_regs.sv ----
// Testbench: register bank driven through its register port and conversion inputs
module tb_pmr_regs;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cv = 1'b0;
	logic rng = 1'b0;
	logic wen = 1'b0;
	logic [15:0] shunt = 16'h0000;
	logic [12:0] busc = 13'h0000;
	logic [7:0] addr;
	logic [15:0] wdata, rdata;
	logic wr, hi, lo, pw, ov, lvl, oe;
	logic ce = 1'b1;
	int fails = 0;
	int checks_done = 0;
	logic [15:0] rst_exp [9] = '{16'h8000, 16'h7FFF, 16'h0000, 16'hFFF8, 16'h0000,
		16'h0000, 16'h0000, 16'h0000, 16'h0000};
	logic [15:0] lim_v [4] = '{16'h0080, 16'hFF80, 16'h0100, 16'h8000};
	pmr_regs dut_u (.sys_clk_in(clk), .reset_n_in(rst_n), .ce_in(ce), .conv_valid_in(cv),
		.shunt_volt_in(shunt), .calibration_in(16'h0002), .bus_volt_count_in(busc),
		.bus_range_16v_in(rng), .warn_output_enable_in(wen), .reg_addr_in(addr),
		.reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
		.shunt_high_warn_flag_out(hi), .shunt_low_warn_flag_out(lo), .power_warn_flag_out(pw),
		.bus_overvolt_warn_flag_out(ov), .warn_level_out(lvl), .warn_oe_out(oe));
	pmr_host_model host_u (.sys_clk_in(clk), .reg_rdata_in(rdata), .reg_addr_out(addr),
		.reg_wr_out(wr), .reg_wdata_out(wdata));
	// 25 MHz clock
	initial begin
		forever #20 clk = ~clk;
	end
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic rc(input logic [7:0] a, input logic [15:0] exp);
		logic [15:0] v;
		host_u.rd_reg(a, v);
		chk($sformatf("reg %h", a), v, exp);
	endtask : rc
	// One conversion, then flags and pin level
	task automatic conv(input logic [15:0] s, input logic [12:0] b, input logic r,
		input logic [3:0] fexp, input logic lexp);
		@(posedge clk);
		shunt <= s;
		busc <= b;
		rng <= r;
		cv <= 1'b1;
		@(posedge clk);
		cv <= 1'b0;
		@(negedge clk);
		chk("flags", {12'h000, hi, lo, pw, ov}, {12'h000, fexp});
		chk("pin", {15'h0000, lvl}, {15'h0000, lexp});
		chk("pin enable", {15'h0000, oe}, {15'h0000, ~lexp});
	endtask : conv
	task automatic complete_run();
		$display("Checks made %0d, mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : complete_run
	// Hang guard
	initial begin
		repeat (5000) @(posedge clk);
		fails++;
		complete_run();
	end
	// Main sequence
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		for (int i = 0; i < 9; i++) begin
			rc(8'h07 + 8'(i), rst_exp[i]);
		end
		// Clock enable low: a conversion must leave every flag and peak untouched
		@(posedge clk);
		ce <= 1'b0;
		conv(16'h0100, 13'h1000, 1'b0, 4'b0000, 1'b1);
		@(posedge clk);
		ce <= 1'b1;
		rc(8'h07, 16'h8000);
		conv(16'h0100, 13'h1000, 1'b0, 4'b1011, 1'b1);
		rc(8'h06, 16'h0200);
		rc(8'h05, 16'h01A3);
		rc(8'h04, 16'h8000);
		conv(16'hFFF0, 13'h1F40, 1'b1, 4'b0111, 1'b1);
		rc(8'h04, 16'h7A00);
		rc(8'h06, 16'hFFE0);
		rc(8'h07, 16'h0100);
		rc(8'h08, 16'hFFF0);
		rc(8'h09, 16'h8000);
		rc(8'h0A, 16'h7A00);
		rc(8'h0B, 16'h01A3);
		host_u.wr_reg(8'h04, 16'h1234);
		rc(8'h04, 16'h7A00);
		rc(8'h20, 16'h0000);
		host_u.wr_reg(8'h07, 16'h7FFE);
		rc(8'h07, 16'h0100);
		for (int i = 0; i < 5; i++) begin
			host_u.clr_peak(8'h07 + 8'(i));
			rc(8'h07 + 8'(i), rst_exp[i]);
		end
		host_u.wr_reg(8'h0F, 16'hFFFF);
		rc(8'h0F, 16'hFFFB);
		for (int i = 0; i < 4; i++) begin
			host_u.wr_reg(8'h0C + 8'(i), lim_v[i]);
			rc(8'h0C + 8'(i), lim_v[i]);
		end
		@(posedge clk);
		wen <= 1'b1;
		conv(16'h0100, 13'h1000, 1'b0, 4'b1010, 1'b0);
		conv(16'hFF00, 13'h1001, 1'b0, 4'b0111, 1'b0);
		conv(16'h0000, 13'h0000, 1'b0, 4'b0000, 1'b1);
		@(posedge clk);
		wen <= 1'b0;
		conv(16'h0100, 13'h0000, 1'b0, 4'b1000, 1'b1);
		@(posedge clk);
		wen <= 1'b1;
		host_u.wr_reg(8'h0F, 16'h8002);
		conv(16'h0100, 13'h0000, 1'b0, 4'b1000, 1'b1);
		conv(16'h0000, 13'h0000, 1'b0, 4'b0000, 1'b0);
		host_u.wr_reg(8'h0F, 16'h8001);
		conv(16'h0100, 13'h0000, 1'b0, 4'b1000, 1'b0);
		conv(16'h0000, 13'h0000, 1'b0, 4'b0000, 1'b0);
		host_u.wr_reg(8'h0F, 16'h8000);
		@(negedge clk);
		chk("pin", {15'h0000, lvl}, 16'h0001);
		complete_run();
	end
endmodule : tb_pmr_regs
